// >>> design/thermal_power_pkg.sv
package thermal_power_pkg;

    // Service selectors on the request port
    localparam logic [3:0] SVC_TEMP_TARGET = 4'h0;
    localparam logic [3:0] SVC_THERMAL_STATUS = 4'h1;
    localparam logic [3:0] SVC_AVG_CONSTANT = 4'h2;
    localparam logic [3:0] SVC_CONSTRAINED_TIME = 4'h3;
    localparam logic [3:0] SVC_CURRENT_CAP = 4'h4;
    localparam logic [3:0] SVC_ENERGY = 4'h5;
    localparam logic [3:0] SVC_POWER_CAP = 4'h6;
    localparam logic [3:0] SVC_UNITS = 4'h7;

    // Completion codes
    localparam logic [7:0] CC_PASS = 8'h40;
    localparam logic [7:0] CC_FAIL = 8'h90;

    // Energy domain parameter
    localparam logic [7:0] ENERGY_DOMAIN_PACKAGE = 8'h00;
    localparam logic [7:0] ENERGY_DOMAIN_CORE = 8'h01;

    // Temperature target word fields
    localparam int TJMAX_LSB = 16;
    localparam int FAN_THRESHOLD_LSB = 8;

    // Thermal status word: live status bits and sticky log bits
    localparam int CTL_STATUS_BIT = 0;
    localparam int CTL_LOG_BIT = 1;
    localparam int THROTTLE_STATUS_BIT = 2;
    localparam int THROTTLE_LOG_BIT = 3;
    localparam int CRITICAL_STATUS_BIT = 4;
    localparam int CRITICAL_LOG_BIT = 5;
    localparam logic [31:0] LEGAL_CLEAR_BITS = 32'h0000002a;

    // Averaging constant
    localparam logic [3:0] AVG_CONSTANT_RESET = 4'h4;
    localparam logic [3:0] AVG_CONSTANT_MAX = 4'h8;

    // Current cap, 1/8 A per step, low 13 bits
    localparam int CURRENT_CAP_WIDTH = 13;
    localparam logic [12:0] CURRENT_CAP_RESET = 13'h0438;

    // Core plane power cap control word
    localparam int CAP_LIMIT_LSB = 0;
    localparam int CAP_LIMIT_WIDTH = 15;
    localparam int CAP_ENABLE_BIT = 15;
    localparam int CAP_CLAMP_BIT = 16;
    localparam int CAP_WINDOW_LSB = 17;
    localparam int CAP_WINDOW_WIDTH = 7;
    localparam logic [31:0] CAP_WRITABLE_BITS = 32'h00ffffff;

    // Unit word: power [3:0], energy [12:8], time [19:16]
    localparam logic [3:0] POWER_UNIT_CODE = 4'h3;
    localparam logic [4:0] ENERGY_UNIT_CODE = 5'h10;
    localparam logic [3:0] TIME_UNIT_CODE = 4'ha;

    // Constrained time counter resolution
    localparam int CLK_PERIOD_NS = 20;
    localparam int TIME_TICK_NS = 1000000;
    localparam int TIME_TICK_CYCLES = TIME_TICK_NS / CLK_PERIOD_NS;

endpackage : thermal_power_pkg

// >>> design/temp_average_filter.sv
`timescale 1ns/1ps

// Running average over a window of 2**windowLog2 samples
module temp_average_filter #(
    parameter int WIDTH = 16,
    parameter int MAX_LOG2 = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEnable,
    input wire logic sampleValid,
    input wire logic [WIDTH-1:0] sample,
    input wire logic [3:0] windowLog2,
    output logic [WIDTH-1:0] average
);

    localparam int ACC_WIDTH = WIDTH + MAX_LOG2;

    logic [ACC_WIDTH-1:0] acc;
    logic [ACC_WIDTH-1:0] next_acc;
    logic [ACC_WIDTH-1:0] shifted;

    always_comb begin
        next_acc = acc - (acc >> windowLog2)
                   + {{MAX_LOG2{1'b0}}, sample};
        shifted = next_acc >> windowLog2;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            acc <= '0;
        end else if (clkEnable && sampleValid) begin
            acc <= next_acc;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            average <= '0;
        end else if (clkEnable && sampleValid) begin
            if (windowLog2 == 4'h0) begin
                average <= sample;
            end else begin
                average <= shifted[WIDTH-1:0];
            end
        end
    end

endmodule : temp_average_filter

// >>> design/thermal_power_services.sv
`timescale 1ns/1ps

module thermal_power_services #(
    parameter int TEMP_WIDTH = 16,
    parameter int MS_TICKS = thermal_power_pkg::TIME_TICK_CYCLES,
    parameter logic [12:0] CURRENT_CAP = thermal_power_pkg::CURRENT_CAP_RESET
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEnable,
    // Request from the platform_env_control_link command decoder
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [3:0] reqService,
    input wire logic [7:0] reqParam,
    input wire logic [31:0] reqData,
    output logic rspValid,
    output logic [7:0] rspCode,
    output logic [31:0] rspData,
    // Package thermal sources
    input wire logic [7:0] junctionTempMax,
    input wire logic [7:0] fanControlThreshold,
    input wire logic thermalControlCircuitActive,
    input wire logic throttlePinAsserted,
    input wire logic criticalTemp,
    input wire logic thermallyConstrained,
    input wire logic constraintFromThrottlePin,
    input wire logic tempSampleValid,
    input wire logic [TEMP_WIDTH-1:0] tempSample,
    output logic [TEMP_WIDTH-1:0] reportedTemp,
    // Energy increments in energy units, added every cycle that clkEnable is high
    input wire logic [15:0] packageEnergyStep,
    input wire logic [15:0] coreEnergyStep,
    // Core plane power capping controls
    output logic [14:0] powerCapLimit,
    output logic [6:0] powerCapWindow,
    output logic powerCapActive,
    output logic belowOsRequestAllowed,
    output logic coreTurboAllowed
);

    localparam int TICK_WIDTH = $clog2(MS_TICKS + 1);
    localparam logic [TICK_WIDTH-1:0] TICK_LAST =
        TICK_WIDTH'(MS_TICKS - 1);

    // Sticky log update; set beats clear so an edge is never lost
    function automatic logic logNext(
        input logic logBit,
        input logic rise,
        input logic clearReq
    );
        logic cleared;
        cleared = clearReq ? 1'b0 : logBit;
        return cleared | rise;
    endfunction : logNext

    // Only services that accept writes
    function automatic logic isWritable(input logic [3:0] svc);
        return (svc == thermal_power_pkg::SVC_AVG_CONSTANT) ||
               (svc == thermal_power_pkg::SVC_POWER_CAP);
    endfunction : isWritable

    logic take;
    logic isStatusRead;
    logic maskIllegal;
    logic clearAccepted;
    logic [31:0] statusWord;
    logic [31:0] capWord;
    logic [31:0] unitWord;
    logic [31:0] next_rspData;
    logic [7:0] next_rspCode;

    logic ctlPrev;
    logic throttlePrev;
    logic criticalPrev;
    logic ctlLog;
    logic throttleLog;
    logic criticalLog;

    logic [3:0] avgConstant;
    logic [TICK_WIDTH-1:0] tickCount;
    logic msTick;
    logic [31:0] constrainedTime;
    logic [31:0] packageEnergy;
    logic [31:0] coreEnergy;

    logic capEnable;
    logic capClamp;
    logic capProgrammed;

    assign take = reqValid && clkEnable;
    assign isStatusRead = !reqWrite &&
        (reqService == thermal_power_pkg::SVC_THERMAL_STATUS);
    assign maskIllegal =
        |(~reqData & ~thermal_power_pkg::LEGAL_CLEAR_BITS);
    assign clearAccepted = take && isStatusRead && !maskIllegal;

    always_comb begin
        statusWord = '0;
        statusWord[thermal_power_pkg::CTL_STATUS_BIT] =
            thermalControlCircuitActive;
        statusWord[thermal_power_pkg::CTL_LOG_BIT] = ctlLog;
        statusWord[thermal_power_pkg::THROTTLE_STATUS_BIT] =
            throttlePinAsserted;
        statusWord[thermal_power_pkg::THROTTLE_LOG_BIT] = throttleLog;
        statusWord[thermal_power_pkg::CRITICAL_STATUS_BIT] = criticalTemp;
        statusWord[thermal_power_pkg::CRITICAL_LOG_BIT] = criticalLog;
    end

    always_comb begin
        capWord = '0;
        capWord[thermal_power_pkg::CAP_LIMIT_LSB +:
                thermal_power_pkg::CAP_LIMIT_WIDTH] = powerCapLimit;
        capWord[thermal_power_pkg::CAP_ENABLE_BIT] = capEnable;
        capWord[thermal_power_pkg::CAP_CLAMP_BIT] = capClamp;
        capWord[thermal_power_pkg::CAP_WINDOW_LSB +:
                thermal_power_pkg::CAP_WINDOW_WIDTH] = powerCapWindow;
    end

    always_comb begin
        unitWord = '0;
        unitWord[3:0] = thermal_power_pkg::POWER_UNIT_CODE;
        unitWord[12:8] = thermal_power_pkg::ENERGY_UNIT_CODE;
        unitWord[19:16] = thermal_power_pkg::TIME_UNIT_CODE;
    end

    // Answer selection
    always_comb begin
        next_rspData = '0;
        next_rspCode = thermal_power_pkg::CC_PASS;
        if (reqWrite && !isWritable(reqService)) begin
            next_rspCode = thermal_power_pkg::CC_FAIL;
        end else begin
            case (reqService)
                thermal_power_pkg::SVC_TEMP_TARGET: begin
                    next_rspData[thermal_power_pkg::TJMAX_LSB +: 8] =
                        junctionTempMax;
                    next_rspData[thermal_power_pkg::FAN_THRESHOLD_LSB +: 8] =
                        fanControlThreshold;
                end
                thermal_power_pkg::SVC_THERMAL_STATUS: begin
                    if (maskIllegal) begin
                        next_rspCode = thermal_power_pkg::CC_FAIL;
                    end else begin
                        next_rspData = statusWord;
                    end
                end
                thermal_power_pkg::SVC_AVG_CONSTANT: begin
                    if (reqWrite &&
                        reqData > 32'(thermal_power_pkg::AVG_CONSTANT_MAX))
                    begin
                        next_rspCode = thermal_power_pkg::CC_FAIL;
                    end else if (!reqWrite) begin
                        next_rspData[3:0] = avgConstant;
                    end
                end
                thermal_power_pkg::SVC_CONSTRAINED_TIME: begin
                    next_rspData = constrainedTime;
                end
                thermal_power_pkg::SVC_CURRENT_CAP: begin
                    next_rspData[thermal_power_pkg::CURRENT_CAP_WIDTH-1:0] =
                        CURRENT_CAP;
                end
                thermal_power_pkg::SVC_ENERGY: begin
                    if (reqParam == thermal_power_pkg::ENERGY_DOMAIN_PACKAGE)
                    begin
                        next_rspData = packageEnergy;
                    end else if (reqParam ==
                                 thermal_power_pkg::ENERGY_DOMAIN_CORE) begin
                        next_rspData = coreEnergy;
                    end else begin
                        next_rspCode = thermal_power_pkg::CC_FAIL;
                    end
                end
                thermal_power_pkg::SVC_POWER_CAP: begin
                    if (!reqWrite) begin
                        next_rspData = capWord;
                    end
                end
                thermal_power_pkg::SVC_UNITS: begin
                    next_rspData = unitWord;
                end
                default: begin
                    next_rspCode = thermal_power_pkg::CC_FAIL;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rspValid <= 1'b0;
            rspCode <= '0;
            rspData <= '0;
        end else if (clkEnable) begin
            rspValid <= reqValid;
            if (reqValid) begin
                rspCode <= next_rspCode;
                rspData <= next_rspData;
            end
        end
    end

    // Edge history for the sticky logs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctlPrev <= 1'b0;
            throttlePrev <= 1'b0;
            criticalPrev <= 1'b0;
        end else if (clkEnable) begin
            ctlPrev <= thermalControlCircuitActive;
            throttlePrev <= throttlePinAsserted;
            criticalPrev <= criticalTemp;
        end
    end

    // Logs leave only through a legal masked status read or reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ctlLog <= 1'b0;
            throttleLog <= 1'b0;
            criticalLog <= 1'b0;
        end else if (clkEnable) begin
            ctlLog <= logNext(ctlLog,
                thermalControlCircuitActive && !ctlPrev,
                clearAccepted &&
                !reqData[thermal_power_pkg::CTL_LOG_BIT]);
            throttleLog <= logNext(throttleLog,
                throttlePinAsserted && !throttlePrev,
                clearAccepted &&
                !reqData[thermal_power_pkg::THROTTLE_LOG_BIT]);
            criticalLog <= logNext(criticalLog,
                criticalTemp && !criticalPrev,
                clearAccepted &&
                !reqData[thermal_power_pkg::CRITICAL_LOG_BIT]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            avgConstant <= thermal_power_pkg::AVG_CONSTANT_RESET;
        end else if (take && reqWrite &&
                     reqService == thermal_power_pkg::SVC_AVG_CONSTANT &&
                     reqData <= 32'(thermal_power_pkg::AVG_CONSTANT_MAX))
        begin
            avgConstant <= reqData[3:0];
        end
    end

    temp_average_filter #(
        .WIDTH(TEMP_WIDTH),
        .MAX_LOG2(8)
    ) u_filter (
        .clk_sys(clk_sys),
        .reset(reset),
        .clkEnable(clkEnable),
        .sampleValid(tempSampleValid),
        .sample(tempSample),
        .windowLog2(avgConstant),
        .average(reportedTemp)
    );

    // Millisecond time base; free running so each count is a whole ms
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tickCount <= '0;
        end else if (clkEnable) begin
            if (tickCount == TICK_LAST) begin
                tickCount <= '0;
            end else begin
                tickCount <= tickCount + 1'b1;
            end
        end
    end

    assign msTick = (tickCount == TICK_LAST);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            constrainedTime <= '0;
        end else if (clkEnable && msTick && thermallyConstrained &&
                     !constraintFromThrottlePin) begin
            constrainedTime <= constrainedTime + 32'h1;
        end
    end

    // Energy accumulators wrap; the host differences them
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            packageEnergy <= '0;
            coreEnergy <= '0;
        end else if (clkEnable) begin
            packageEnergy <= packageEnergy + {16'h0, packageEnergyStep};
            coreEnergy <= coreEnergy + {16'h0, coreEnergyStep};
        end
    end

    // Whole word taken at once; reserved bits dropped
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            capEnable <= 1'b0;
            capClamp <= 1'b0;
            capProgrammed <= 1'b0;
        end else if (take && reqWrite &&
                     reqService == thermal_power_pkg::SVC_POWER_CAP) begin
            capEnable <= reqData[thermal_power_pkg::CAP_ENABLE_BIT];
            capClamp <= reqData[thermal_power_pkg::CAP_CLAMP_BIT];
            capProgrammed <= 1'b1;
        end
    end

    // Limit and window hold no reset value: software must program them
    always_ff @(posedge clk_sys) begin
        if (take && reqWrite &&
            reqService == thermal_power_pkg::SVC_POWER_CAP) begin
            powerCapLimit <= reqData[thermal_power_pkg::CAP_LIMIT_LSB +:
                thermal_power_pkg::CAP_LIMIT_WIDTH];
            powerCapWindow <= reqData[thermal_power_pkg::CAP_WINDOW_LSB +:
                thermal_power_pkg::CAP_WINDOW_WIDTH];
        end
    end

    assign powerCapActive = capEnable;
    assign belowOsRequestAllowed = capEnable && capClamp;
    assign coreTurboAllowed = capProgrammed;

endmodule : thermal_power_services

// >>> sim/thermal_power_services_chk.sv
`timescale 1ns/1ps
module thermal_power_services_chk #(
    parameter logic [12:0] CURRENT_CAP = 13'h0438
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEnable,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [3:0] reqService,
    input wire logic [31:0] reqData,
    input wire logic rspValid,
    input wire logic [7:0] rspCode,
    input wire logic [31:0] rspData,
    input wire logic [7:0] junctionTempMax,
    input wire logic [7:0] fanControlThreshold,
    input wire logic [14:0] powerCapLimit,
    input wire logic [6:0] powerCapWindow,
    input wire logic powerCapActive,
    input wire logic belowOsRequestAllowed,
    input wire logic coreTurboAllowed
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic taken;
    logic rdTaken;
    assign taken = reqValid && clkEnable;
    assign rdTaken = taken && !reqWrite;
    chk_answer_next:
        assert property (taken |=> rspValid)
        else $error("no answer");
    chk_no_stray:
        assert property (!taken |=> !rspValid)
        else $error("stray answer");
    chk_target_fields:
        assert property (rdTaken && reqService == 4'h0 |=>
            rspData == {8'h00, $past(junctionTempMax),
            $past(fanControlThreshold), 8'h00})
        else $error("target word wrong");
    chk_cap_value:
        assert property (rdTaken && reqService == 4'h4 |=>
            rspData == {19'h00000, CURRENT_CAP} && rspCode == 8'h40)
        else $error("current cap wrong");
    chk_unit_word:
        assert property (rdTaken && reqService == 4'h7 |=>
            rspData == 32'h000a1003)
        else $error("unit word wrong");
    chk_status_clean:
        assert property (rdTaken && reqService == 4'h1 |=>
            rspData[31:6] == 26'h0)
        else $error("status reserved set");
    chk_bad_mask:
        assert property (rdTaken && reqService == 4'h1 &&
            ((~reqData & 32'hffffffd5) != 32'h0) |=>
            rspCode == 8'h90 && rspData == 32'h0)
        else $error("bad mask taken");
    chk_cap_fields:
        assert property (taken && reqWrite && reqService == 4'h6 |=>
            powerCapLimit == $past(reqData[14:0]) &&
            powerCapWindow == $past(reqData[23:17]) &&
            powerCapActive == $past(reqData[15]) && coreTurboAllowed)
        else $error("cap fields wrong");
    chk_clamp_gate:
        assert property (belowOsRequestAllowed |-> powerCapActive)
        else $error("clamp without enable");
    chk_turbo_holds:
        assert property (coreTurboAllowed |=> coreTurboAllowed)
        else $error("turbo dropped");
    chk_reset_off:
        assert property ($fell(reset) |-> !powerCapActive &&
            !coreTurboAllowed)
        else $error("capping on after reset");
endmodule : thermal_power_services_chk

bind thermal_power_services thermal_power_services_chk #(
    .CURRENT_CAP(CURRENT_CAP)
) u_chk (.clk_sys(clk_sys), .reset(reset), .clkEnable(clkEnable),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqService(reqService),
    .reqData(reqData), .rspValid(rspValid), .rspCode(rspCode),
    .rspData(rspData), .junctionTempMax(junctionTempMax),
    .fanControlThreshold(fanControlThreshold),
    .powerCapLimit(powerCapLimit), .powerCapWindow(powerCapWindow),
    .powerCapActive(powerCapActive),
    .belowOsRequestAllowed(belowOsRequestAllowed),
    .coreTurboAllowed(coreTurboAllowed));

// >>> sim/link_host_model.sv
`timescale 1ns/1ps
module link_host_model (
    input wire logic clk_sys,
    input wire logic rspValid,
    input wire logic [7:0] rspCode,
    input wire logic [31:0] rspData,
    output logic reqValid,
    output logic reqWrite,
    output logic [3:0] reqService,
    output logic [7:0] reqParam,
    output logic [31:0] reqData
);
    initial begin
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqService = 4'h0;
        reqParam = 8'h00;
        reqData = 32'h0;
    end
    // Released qualifiers are inverted so stale values never match
    task automatic xfer(input logic wr, input logic [3:0] svc,
        input logic [7:0] prm, input logic [31:0] dat, output logic ok,
        output logic [7:0] code, output logic [31:0] rdat);
        @(negedge clk_sys);
        reqValid = 1'b1;
        reqWrite = wr;
        reqService = svc;
        reqParam = prm;
        reqData = dat;
        @(negedge clk_sys);
        ok = rspValid;
        code = rspCode;
        rdat = rspData;
        reqValid = 1'b0;
        reqWrite = ~wr;
        reqService = ~svc;
        reqParam = ~prm;
        reqData = ~dat;
    endtask : xfer
    // Whole word every time, even for a one-field change
    task automatic cap_write(input logic [14:0] lim, input logic en,
        input logic clamp, input logic [6:0] win, input logic [7:0] resv,
        output logic [7:0] code);
        logic ok;
        logic [31:0] d;
        xfer(1'b1, 4'h6, 8'h00, {resv, win, clamp, en, lim}, ok, code,
            d);
    endtask : cap_write
    // Reads two cycles apart, far inside the polling limit
    task automatic energy_delta(input logic [7:0] dom,
        output logic [7:0] code, output logic [31:0] delta);
        logic ok;
        logic [31:0] a;
        logic [31:0] b;
        xfer(1'b0, 4'h5, dom, 32'h0, ok, code, a);
        xfer(1'b0, 4'h5, dom, 32'h0, ok, code, b);
        delta = b - a;
    endtask : energy_delta
endmodule : link_host_model

// >>> sim/pkg_thermal_power_services_bench.sv
`timescale 1ns/1ps
module pkg_thermal_power_services_bench;
    logic clk_sys, reset, clkEnable, reqValid, reqWrite, rspValid;
    logic [3:0] reqService;
    logic [7:0] reqParam, rspCode, junctionTempMax, fanControlThreshold;
    logic [31:0] reqData, rspData, dat, d2;
    logic thermalControlCircuitActive, throttlePinAsserted, criticalTemp;
    logic thermallyConstrained, constraintFromThrottlePin;
    logic tempSampleValid, ok;
    logic [15:0] tempSample, reportedTemp, packageEnergyStep, coreEnergyStep;
    logic [14:0] powerCapLimit;
    logic [6:0] powerCapWindow;
    logic powerCapActive, belowOsRequestAllowed, coreTurboAllowed;
    logic [2:0] capFlags;
    logic [7:0] code;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    thermal_power_services #(.MS_TICKS(10)) u_thermal_power_services (
        .clk_sys(clk_sys), .reset(reset), .clkEnable(clkEnable),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqService(reqService),
        .reqParam(reqParam), .reqData(reqData), .rspValid(rspValid),
        .rspCode(rspCode), .rspData(rspData),
        .junctionTempMax(junctionTempMax),
        .fanControlThreshold(fanControlThreshold),
        .thermalControlCircuitActive(thermalControlCircuitActive),
        .throttlePinAsserted(throttlePinAsserted),
        .criticalTemp(criticalTemp),
        .thermallyConstrained(thermallyConstrained),
        .constraintFromThrottlePin(constraintFromThrottlePin),
        .tempSampleValid(tempSampleValid), .tempSample(tempSample),
        .reportedTemp(reportedTemp), .packageEnergyStep(packageEnergyStep),
        .coreEnergyStep(coreEnergyStep), .powerCapLimit(powerCapLimit),
        .powerCapWindow(powerCapWindow), .powerCapActive(powerCapActive),
        .belowOsRequestAllowed(belowOsRequestAllowed),
        .coreTurboAllowed(coreTurboAllowed));
    link_host_model u_link_host_model (.clk_sys(clk_sys),
        .rspValid(rspValid), .rspCode(rspCode), .rspData(rspData),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqService(reqService),
        .reqParam(reqParam), .reqData(reqData));

    assign capFlags = {powerCapActive, belowOsRequestAllowed,
        coreTurboAllowed};
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Run needs under 1000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            $display("BAD %0t timeout", $time);
            stop_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic rq(input logic wr, input logic [3:0] svc,
        input logic [31:0] d, input logic [7:0] cc);
        u_link_host_model.xfer(wr, svc, 8'h00, d, ok, code, dat);
        check({31'h0, ok}, 32'h1, "strobe");
        check({24'h0, code}, {24'h0, cc}, "code");
    endtask : rq
    task automatic t_defaults;
        rq(1'b0, 4'h2, 32'h0, 8'h40);
        check(dat, 32'h4, "avg constant");
        rq(1'b0, 4'h4, 32'h0, 8'h40);
        check(dat, 32'h00000438, "current cap");
        rq(1'b0, 4'h7, 32'h0, 8'h40);
        check(dat, 32'h000a1003, "unit word");
        rq(1'b0, 4'h0, 32'h0, 8'h40);
        check(dat, 32'h005a4b00, "target word");
        check(32'(capFlags), 32'h0, "cap off");
        $display("test defaults done");
    endtask : t_defaults
    task automatic t_status;
        thermalControlCircuitActive = 1'b1;
        throttlePinAsserted = 1'b1;
        criticalTemp = 1'b1;
        rq(1'b0, 4'h1, '1, 8'h40);
        check(dat, 32'h3f, "live and logs");
        thermalControlCircuitActive = 1'b0;
        throttlePinAsserted = 1'b0;
        criticalTemp = 1'b0;
        rq(1'b1, 4'h1, 32'h0, 8'h90);
        rq(1'b0, 4'h1, 32'hfffffffe, 8'h90);
        check(dat, 32'h0, "refused data");
        rq(1'b0, 4'h1, 32'hfffffffd, 8'h40);
        check(dat, 32'h2a, "logs held");
        rq(1'b0, 4'h1, '1, 8'h40);
        check(dat, 32'h28, "one log cleared");
        rq(1'b0, 4'h1, 32'hffffffd7, 8'h40);
        rq(1'b0, 4'h1, '1, 8'h40);
        check(dat, 32'h0, "all logs cleared");
        $display("test status done");
    endtask : t_status
    task automatic t_avg;
        rq(1'b1, 4'h2, 32'h9, 8'h90);
        rq(1'b1, 4'h2, 32'h8, 8'h40);
        rq(1'b0, 4'h2, 32'h0, 8'h40);
        check(dat, 32'h8, "largest window");
        rq(1'b1, 4'h2, 32'h0, 8'h40);
        tempSampleValid = 1'b1;
        tempSample = 16'h1234;
        @(negedge clk_sys);
        tempSampleValid = 1'b0;
        @(negedge clk_sys);
        check({16'h0, reportedTemp}, 32'h1234, "unfiltered");
        $display("test averaging done");
    endtask : t_avg
    task automatic t_time;
        rq(1'b0, 4'h3, 32'h0, 8'h40);
        d2 = dat;
        thermallyConstrained = 1'b1;
        constraintFromThrottlePin = 1'b1;
        repeat (50) @(negedge clk_sys);
        constraintFromThrottlePin = 1'b0;
        // Frozen cycles add nothing; 50 live cycles hold five ticks
        clkEnable = 1'b0;
        repeat (20) @(negedge clk_sys);
        clkEnable = 1'b1;
        repeat (50) @(negedge clk_sys);
        thermallyConstrained = 1'b0;
        rq(1'b0, 4'h3, 32'h0, 8'h40);
        check(dat - d2, 32'h5, "constrained ticks");
        $display("test constrained time done");
    endtask : t_time
    task automatic t_energy;
        u_link_host_model.energy_delta(8'h00, code, dat);
        check(dat, 32'h6, "package energy");
        u_link_host_model.energy_delta(8'h01, code, dat);
        check(dat, 32'h2, "core energy");
        u_link_host_model.xfer(1'b0, 4'h5, 8'h02, 32'h0, ok, code, dat);
        check({24'h0, code}, 32'h90, "bad domain");
        $display("test energy done");
    endtask : t_energy
    task automatic t_power_cap;
        u_link_host_model.cap_write(15'h1234, 1'b1, 1'b0, 7'h55, 8'hff, code);
        check({powerCapLimit, powerCapWindow}, 32'h91a55, "cap out");
        check(32'(capFlags), 32'h5, "enable only");
        rq(1'b0, 4'h6, 32'h0, 8'h40);
        check(dat, 32'h00aa9234, "cap word");
        u_link_host_model.cap_write(15'h0001, 1'b0, 1'b1, 7'h01, 8'h0, code);
        check(32'(capFlags), 32'h1, "clamp only");
        u_link_host_model.cap_write(15'h7fff, 1'b1, 1'b1, 7'h7f, 8'h0, code);
        check(32'(capFlags), 32'h7, "enable and clamp");
        rq(1'b1, 4'h4, 32'h0, 8'h90);
        for (int s = 8; s < 16; s++) begin
            rq(1'b0, 4'(s), 32'h0, 8'h90);
        end
        $display("test power cap done");
    endtask : t_power_cap
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        reset = 1'b1;
        clkEnable = 1'b1;
        junctionTempMax = 8'h5a;
        fanControlThreshold = 8'h4b;
        thermalControlCircuitActive = 1'b0;
        throttlePinAsserted = 1'b0;
        criticalTemp = 1'b0;
        thermallyConstrained = 1'b0;
        constraintFromThrottlePin = 1'b0;
        tempSampleValid = 1'b0;
        tempSample = 16'h0;
        packageEnergyStep = 16'h0003;
        coreEnergyStep = 16'h0001;
        repeat (5) @(negedge clk_sys);
        reset = 1'b0;
        t_defaults();
        t_status();
        t_avg();
        t_time();
        t_energy();
        t_power_cap();
        stop_test();
    end
endmodule : pkg_thermal_power_services_bench
